// File: hw/fsd_pkg.sv
// Constants shared by the synthesizer divider block.
// Assumes one system clock; every pin input is already synchronous to it.
package fsd_pkg;

	// Serial programming word: address in the top bits, payload below
	localparam int FSD_WORD_W = 20;
	localparam int FSD_ADDR_W = 3;
	localparam int FSD_DATA_W = 17;
	localparam int FSD_ADDR_LSB = 17;
	localparam int FSD_CNT_W = 5;

	// Target register addresses
	localparam logic [2:0] FSD_ADDR_RX = 3'h0;
	localparam logic [2:0] FSD_ADDR_TX = 3'h1;
	localparam logic [2:0] FSD_ADDR_REF = 3'h2;
	localparam logic [2:0] FSD_ADDR_MODE = 3'h3;
	localparam logic [2:0] FSD_ADDR_GAIN = 3'h4;

	// Main divider word layout
	localparam int FSD_INT_W = 14;
	localparam int FSD_FRAC_W = 3;
	localparam int FSD_FRAC_LSB = 0;
	localparam int FSD_INT_LSB = 3;

	// Reference register layout
	localparam int FSD_REFDIV_W = 11;
	localparam int FSD_REFDIV_LSB = 0;
	localparam int FSD_PDR_W = 3;
	localparam int FSD_PDR_LSB = 11;

	// Mode register bits
	localparam int FSD_MODE_RX_EN = 0;
	localparam int FSD_MODE_TX_EN = 1;
	localparam int FSD_MODE_KEEP_REF = 2;

	// Gain register layout
	localparam int FSD_GAIN_PAD = 0;
	localparam int FSD_GAIN_MIX_LSB = 1;
	localparam int FSD_GAIN_VGA_LSB = 3;
	localparam int FSD_GAIN_AGC = 5;
	localparam logic [1:0] FSD_VGA_MAX = 2'h2;

	// Reset values
	localparam logic [16:0] FSD_RST_DIV = 17'h00000;
	localparam logic [10:0] FSD_RST_REFDIV = 11'h001;
	localparam logic [2:0] FSD_RST_PDR = 3'h0;
	localparam logic [2:0] FSD_RST_MODE = 3'h0;
	localparam logic [5:0] FSD_RST_GAIN = 6'h00;

	// Demodulator period counter and output width
	localparam int FSD_DAC_W = 8;
	localparam logic [7:0] FSD_DAC_MAX = 8'hff;

endpackage : fsd_pkg

// File: hw/fsd_fracn_div.sv
// Fractional-N feedback divider with a simple phase/frequency detector.
// Assumes vco_edge and ref_tick are single-cycle pulses in the system clock.
`timescale 1ns/1ps

module fsd_fracn_div
	import fsd_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic enable_in,
	input wire logic vco_edge_in,
	input wire logic ref_tick_in,
	input wire logic [13:0] int_val_in,
	input wire logic [2:0] frac_val_in,
	output logic fb_pulse_out,
	output logic pd_up_out,
	output logic pd_dn_out
);

	logic [2:0] acc_reg;
	logic [14:0] modulus_reg;
	logic [14:0] count_reg;
	logic [3:0] acc_sum;
	logic [14:0] int_ext;
	logic hit;

	assign int_ext = {1'b0, int_val_in};
	assign acc_sum = {1'b0, acc_reg} + {1'b0, frac_val_in};
	assign hit = enable_in && vco_edge_in && (count_reg + 15'h0001 >= modulus_reg);

	//////////////////////////////////////////////////////////////////
	// [R19] Fraction accumulator
	// [R4] Carry stretches one cycle by one VCO edge: 1/8 reference steps
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			acc_reg <= 3'h0;
			modulus_reg <= 15'h0001;
		end else if (!enable_in) begin
			acc_reg <= 3'h0;
			modulus_reg <= int_ext;
		end else if (ref_tick_in) begin
			acc_reg <= acc_sum[2:0];
			modulus_reg <= int_ext + {14'h0000, acc_sum[3]};
		end
	end

	//////////////////////////////////////////////////////////////////
	// [R3] Integer divide of VCO edges
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			count_reg <= 15'h0000;
			fb_pulse_out <= 1'b0;
		end else begin
			fb_pulse_out <= hit;
			if (!enable_in || hit) begin
				count_reg <= 15'h0000;
			end else if (vco_edge_in) begin
				count_reg <= count_reg + 15'h0001;
			end
		end
	end

	//////////////////////////////////////////////////////////////////
	// [R3] Phase detector against the reference
	// Both events together cancel, as a real PFD reset would
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pd_up_out <= 1'b0;
			pd_dn_out <= 1'b0;
		end else if (!enable_in || (ref_tick_in && hit)) begin
			pd_up_out <= 1'b0;
			pd_dn_out <= 1'b0;
		end else if (ref_tick_in) begin
			pd_up_out <= !pd_dn_out;
			pd_dn_out <= 1'b0;
		end else if (hit) begin
			pd_dn_out <= !pd_up_out;
			pd_up_out <= 1'b0;
		end
	end

endmodule : fsd_fracn_div

// File: hw/fsd_top.sv
// Synthesizer dividers, serial programming port, demodulator clocking
// and receive gain selection of an FM transceiver.
// Assumes all pins, VCO and reference inputs are sampled levels that are
// synchronous to CLK_SYS_IN and slower than half its rate.
`timescale 1ns/1ps

// Summary of operation
// [R1] Receive VCO is divided by exactly two to make the receive LO.
// [R2] Each main divider word holds seventeen programmable bits.
// [R3] Fourteen bits give the integer divide compared with the reference.
// [R4] Three fraction bits step the channel by one eighth of reference.
// [R5] Transmit divider matches receive but counts the VCO directly.
// [R6] One eleven-bit reference counter feeds both synthesizers.
// [R7] All eleven reference counter bits are host writable.
// [R8] A three-bit demodulator divide ratio sits in the reference register.
// [R9] The divide ratio selects demodulator bandwidth from 150kHz to 25kHz.
// [R10] Demodulator sampling clock is the receive signal divided by the ratio.
// [R11] Each IF half-cycle is counted in sample ticks and sent to the DAC.
// [R12] The receive LO clocks the receive and demodulator synthesizers.
// [R13] Newer variant: mode bit keeps reference running with both paths off.
// [R14] Older variant: reference stops when transmit and receive are off.
// [R15] Host writes the receive divider word over the three-wire port.
// [R16] Host writes the transmit divider word over the same port.
// [R17] Gain set at pad, four-step mixer load, three-step VGA, or by AGC.
// [R18] Input pad switches 0 or -10dB, manually or from the AGC.
// [R19] Fraction accumulates per reference cycle; overflow adds one to divide.
// [R20] Shifted data reaches a register only on the load-enable strobe.
module fsd_top
	import fsd_pkg::*;
#(
	parameter bit NEWER_VARIANT = 1'b1
)
(
	input wire logic CLK_SYS_IN,
	input wire logic NRST_IN,
	input wire logic SER_DATA_IN,
	input wire logic SER_CLK_IN,
	input wire logic SER_LE_IN,
	input wire logic REF_OSC_IN,
	input wire logic RX_VCO_IN,
	input wire logic TX_VCO_IN,
	input wire logic IF_IN,
	input wire logic AGC_PAD_REQ_IN,
	output logic RX_LO_OUT,
	output logic REF_TICK_OUT,
	output logic REF_RUN_OUT,
	output logic RX_FB_OUT,
	output logic RX_PD_UP_OUT,
	output logic RX_PD_DN_OUT,
	output logic TX_FB_OUT,
	output logic TX_PD_UP_OUT,
	output logic TX_PD_DN_OUT,
	output logic DEMOD_SAMPLE_OUT,
	output logic [7:0] DEMOD_DAC_OUT,
	output logic PAD_ATTEN_OUT,
	output logic [1:0] MIXER_ATTEN_OUT,
	output logic [1:0] VGA_STEP_OUT,
	output logic AGC_EN_OUT
);

	// Ratio for each demodulator setting; larger ratio, narrower bandwidth
	function automatic logic [2:0] fsd_demod_ratio(input logic [2:0] sel);
		logic [2:0] r;
		r = 3'h6;
		unique case (sel)
			3'h0: r = 3'h1;
			3'h1: r = 3'h2;
			3'h2: r = 3'h3;
			3'h3: r = 3'h4;
			3'h4: r = 3'h5;
			3'h5: r = 3'h6;
			3'h6: r = 3'h6;
			3'h7: r = 3'h6;
		endcase
		return r;
	endfunction : fsd_demod_ratio

	logic ser_clk_prev_reg;
	logic ser_le_prev_reg;
	logic [19:0] shift_reg;
	logic [16:0] rx_word_reg;
	logic [16:0] tx_word_reg;
	logic [10:0] ref_div_reg;
	logic [2:0] demod_divide_ratio_reg;
	logic [2:0] mode_reg;
	logic [5:0] gain_reg;
	logic ref_prev_reg;
	logic rx_vco_prev_reg;
	logic tx_vco_prev_reg;
	logic if_prev_reg;
	logic [10:0] ref_cnt_reg;
	logic rx_lo_reg;
	logic [2:0] demod_cnt_reg;
	logic [7:0] period_reg;
	logic ref_run;
	logic ref_edge;
	logic ref_hit;
	logic rx_lo_edge;
	logic demod_tick;
	logic rx_en;
	logic tx_en;
	logic [2:0] addr;
	logic [10:0] ref_div_eff;
	logic [2:0] demod_ratio;
	logic [1:0] vga_req;

	//////////////////////////////////////////////////////////////////
	// Serial programming port

	// [R15] [R16] Shift on serial clock rise
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ser_clk_prev_reg <= 1'b0;
			ser_le_prev_reg <= 1'b0;
			shift_reg <= 20'h00000;
		end else begin
			ser_clk_prev_reg <= SER_CLK_IN;
			ser_le_prev_reg <= SER_LE_IN;
			if (SER_CLK_IN && !ser_clk_prev_reg) begin
				shift_reg <= {shift_reg[18:0], SER_DATA_IN};
			end
		end
	end

	assign addr = shift_reg[FSD_ADDR_LSB +: FSD_ADDR_W];

	// [R20] Transfer only on load-enable rise
	// [R2] [R7] [R8] Full-width register loads
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			rx_word_reg <= FSD_RST_DIV;
			tx_word_reg <= FSD_RST_DIV;
			ref_div_reg <= FSD_RST_REFDIV;
			demod_divide_ratio_reg <= FSD_RST_PDR;
			mode_reg <= FSD_RST_MODE;
			gain_reg <= FSD_RST_GAIN;
		end else if (SER_LE_IN && !ser_le_prev_reg) begin
			unique case (addr)
				FSD_ADDR_RX: rx_word_reg <= shift_reg[16:0];
				FSD_ADDR_TX: tx_word_reg <= shift_reg[16:0];
				FSD_ADDR_REF: begin
					ref_div_reg <= shift_reg[FSD_REFDIV_LSB +: FSD_REFDIV_W];
					demod_divide_ratio_reg <= shift_reg[FSD_PDR_LSB +: FSD_PDR_W];
				end
				FSD_ADDR_MODE: mode_reg <= shift_reg[2:0];
				FSD_ADDR_GAIN: gain_reg <= shift_reg[5:0];
				default: begin
				end
			endcase
		end
	end

	assign rx_en = mode_reg[FSD_MODE_RX_EN];
	assign tx_en = mode_reg[FSD_MODE_TX_EN];

	//////////////////////////////////////////////////////////////////
	// Reference synthesizer

	// [R13] Keep-running bit only in the newer variant
	// [R14] Older variant stops with both paths off
	assign ref_run = rx_en || tx_en || (NEWER_VARIANT && mode_reg[FSD_MODE_KEEP_REF]);
	assign ref_edge = REF_OSC_IN && !ref_prev_reg;
	// Ratio of zero behaves as one rather than never ticking
	assign ref_div_eff = (ref_div_reg == 11'h000) ? 11'h001 : ref_div_reg;
	assign ref_hit = ref_run && ref_edge && (ref_cnt_reg + 11'h001 >= ref_div_eff);

	// [R6] Shared eleven-bit reference counter
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ref_prev_reg <= 1'b0;
			ref_cnt_reg <= 11'h000;
			REF_TICK_OUT <= 1'b0;
			REF_RUN_OUT <= 1'b0;
		end else begin
			ref_prev_reg <= REF_OSC_IN;
			REF_TICK_OUT <= ref_hit;
			REF_RUN_OUT <= ref_run;
			if (!ref_run || ref_hit) begin
				ref_cnt_reg <= 11'h000;
			end else if (ref_edge) begin
				ref_cnt_reg <= ref_cnt_reg + 11'h001;
			end
		end
	end

	//////////////////////////////////////////////////////////////////
	// Receive LO and main dividers

	// [R1] Divide receive VCO by two
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			rx_vco_prev_reg <= 1'b0;
			tx_vco_prev_reg <= 1'b0;
			rx_lo_reg <= 1'b0;
		end else begin
			rx_vco_prev_reg <= RX_VCO_IN;
			tx_vco_prev_reg <= TX_VCO_IN;
			if (!rx_en) begin
				rx_lo_reg <= 1'b0;
			end else if (RX_VCO_IN && !rx_vco_prev_reg) begin
				rx_lo_reg <= !rx_lo_reg;
			end
		end
	end

	assign RX_LO_OUT = rx_lo_reg;
	// [R12] LO rise clocks both receive-side synthesizers
	assign rx_lo_edge = rx_en && RX_VCO_IN && !rx_vco_prev_reg && !rx_lo_reg;

	// [R3] [R4] Receive divider on the LO
	fsd_fracn_div u_rx_div (
		.clk_in(CLK_SYS_IN),
		.nrst_in(NRST_IN),
		.enable_in(rx_en),
		.vco_edge_in(rx_lo_edge),
		.ref_tick_in(REF_TICK_OUT),
		.int_val_in(rx_word_reg[FSD_INT_LSB +: FSD_INT_W]),
		.frac_val_in(rx_word_reg[FSD_FRAC_LSB +: FSD_FRAC_W]),
		.fb_pulse_out(RX_FB_OUT),
		.pd_up_out(RX_PD_UP_OUT),
		.pd_dn_out(RX_PD_DN_OUT)
	);

	// [R5] Transmit divider counts the VCO itself
	fsd_fracn_div u_tx_div (
		.clk_in(CLK_SYS_IN),
		.nrst_in(NRST_IN),
		.enable_in(tx_en),
		.vco_edge_in(TX_VCO_IN && !tx_vco_prev_reg),
		.ref_tick_in(REF_TICK_OUT),
		.int_val_in(tx_word_reg[FSD_INT_LSB +: FSD_INT_W]),
		.frac_val_in(tx_word_reg[FSD_FRAC_LSB +: FSD_FRAC_W]),
		.fb_pulse_out(TX_FB_OUT),
		.pd_up_out(TX_PD_UP_OUT),
		.pd_dn_out(TX_PD_DN_OUT)
	);

	//////////////////////////////////////////////////////////////////
	// Demodulator synthesizer and period-to-digital demodulator

	// [R9] Ratio 1 to 6 spans 150kHz to 25kHz
	assign demod_ratio = fsd_demod_ratio(demod_divide_ratio_reg);
	assign demod_tick = rx_lo_edge && (demod_cnt_reg + 3'h1 >= demod_ratio);

	// [R10] Sampling clock from the divided LO
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			demod_cnt_reg <= 3'h0;
			DEMOD_SAMPLE_OUT <= 1'b0;
		end else begin
			DEMOD_SAMPLE_OUT <= demod_tick;
			if (!rx_en || demod_tick) begin
				demod_cnt_reg <= 3'h0;
			end else if (rx_lo_edge) begin
				demod_cnt_reg <= demod_cnt_reg + 3'h1;
			end
		end
	end

	// [R11] Half-cycle period to DAC
	// Long periods saturate instead of wrapping to small codes
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			if_prev_reg <= 1'b0;
			period_reg <= 8'h00;
			DEMOD_DAC_OUT <= 8'h00;
		end else begin
			if_prev_reg <= IF_IN;
			if (IF_IN != if_prev_reg) begin
				DEMOD_DAC_OUT <= period_reg;
				period_reg <= {7'h00, demod_tick};
			end else if (demod_tick && period_reg != FSD_DAC_MAX) begin
				period_reg <= period_reg + 8'h01;
			end
		end
	end

	//////////////////////////////////////////////////////////////////
	// Receive gain selection

	// Fourth VGA code is clamped to the top of three steps
	assign vga_req = (gain_reg[FSD_GAIN_VGA_LSB +: 2] > FSD_VGA_MAX) ? FSD_VGA_MAX
		: gain_reg[FSD_GAIN_VGA_LSB +: 2];

	// [R17] Manual steps or AGC
	// [R18] Pad from AGC or manual bit
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			PAD_ATTEN_OUT <= 1'b0;
			MIXER_ATTEN_OUT <= 2'h0;
			VGA_STEP_OUT <= 2'h0;
			AGC_EN_OUT <= 1'b0;
		end else begin
			AGC_EN_OUT <= gain_reg[FSD_GAIN_AGC];
			PAD_ATTEN_OUT <= gain_reg[FSD_GAIN_AGC] ? AGC_PAD_REQ_IN : gain_reg[FSD_GAIN_PAD];
			MIXER_ATTEN_OUT <= gain_reg[FSD_GAIN_MIX_LSB +: 2];
			VGA_STEP_OUT <= vga_req;
		end
	end

endmodule : fsd_top

// File: tb/fsd_props.sv
// Port checker for the synthesizer divider block.
// Assumes it is bound to fsd_top and sees only that module's pins.
`timescale 1ns/1ps
module fsd_props
	import fsd_pkg::*;
#(
	parameter bit NEWER_VARIANT = 1'b1
)
(
	input wire logic CLK_SYS_IN,
	input wire logic NRST_IN,
	input wire logic SER_DATA_IN,
	input wire logic SER_CLK_IN,
	input wire logic SER_LE_IN,
	input wire logic REF_OSC_IN,
	input wire logic RX_VCO_IN,
	input wire logic TX_VCO_IN,
	input wire logic IF_IN,
	input wire logic AGC_PAD_REQ_IN,
	input wire logic RX_LO_OUT,
	input wire logic REF_TICK_OUT,
	input wire logic REF_RUN_OUT,
	input wire logic RX_FB_OUT,
	input wire logic RX_PD_UP_OUT,
	input wire logic RX_PD_DN_OUT,
	input wire logic TX_FB_OUT,
	input wire logic TX_PD_UP_OUT,
	input wire logic TX_PD_DN_OUT,
	input wire logic DEMOD_SAMPLE_OUT,
	input wire logic [7:0] DEMOD_DAC_OUT,
	input wire logic PAD_ATTEN_OUT,
	input wire logic [1:0] MIXER_ATTEN_OUT,
	input wire logic [1:0] VGA_STEP_OUT,
	input wire logic AGC_EN_OUT
);
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!NRST_IN);
	////////////////////////////////////////////////////////////////
	sequence s_vco_rise; $past(RX_VCO_IN) && !$past(RX_VCO_IN, 2); endsequence
	sequence s_if_edge; ($past(IF_IN) != $past(IF_IN, 2)) || ($past(IF_IN, 2) != $past(IF_IN, 3)); endsequence
	property p_lo_rise; $rose(RX_LO_OUT) |-> s_vco_rise; endproperty
	a_lo_rise: assert property (p_lo_rise) else $error("lo rose without vco edge");
	property p_tick; REF_TICK_OUT |=> !REF_TICK_OUT; endproperty
	a_tick: assert property (p_tick) else $error("reference tick too long");
	property p_ref_stop; !REF_RUN_OUT [*2] |-> !REF_TICK_OUT; endproperty
	a_ref_stop: assert property (p_ref_stop) else $error("tick while stopped");
	// Feedback pulse lands in the cycle the LO is first seen high
	property p_rx_fb; RX_FB_OUT |-> $rose(RX_LO_OUT) ##1 !RX_FB_OUT; endproperty
	a_rx_fb: assert property (p_rx_fb) else $error("rx feedback not from lo");
	property p_tx_fb; TX_FB_OUT |-> ($past(TX_VCO_IN) || $past(TX_VCO_IN, 2)) ##1 !TX_FB_OUT; endproperty
	a_tx_fb: assert property (p_tx_fb) else $error("tx feedback not from vco");
	property p_pd_up; $rose(RX_PD_UP_OUT) |-> ##[0:1] (REF_TICK_OUT || $past(REF_TICK_OUT)); endproperty
	a_pd_up: assert property (p_pd_up) else $error("up without reference");
	property p_pd_dn; $rose(TX_PD_DN_OUT) |-> ##[0:1] (TX_FB_OUT || $past(TX_FB_OUT)); endproperty
	a_pd_dn: assert property (p_pd_dn) else $error("down without feedback");
	property p_pd_excl; !(RX_PD_UP_OUT && RX_PD_DN_OUT) && !(TX_PD_UP_OUT && TX_PD_DN_OUT); endproperty
	a_pd_excl: assert property (p_pd_excl) else $error("detector up and down together");
	property p_sample; DEMOD_SAMPLE_OUT |=> !DEMOD_SAMPLE_OUT; endproperty
	a_sample: assert property (p_sample) else $error("sample pulse too long");
	property p_dac; $changed(DEMOD_DAC_OUT) && DEMOD_DAC_OUT != 8'h00 |-> s_if_edge; endproperty
	a_dac: assert property (p_dac) else $error("dac moved without if edge");
	property p_vga; VGA_STEP_OUT <= FSD_VGA_MAX; endproperty
	a_vga: assert property (p_vga) else $error("vga step out of range");
	property p_gain_load;
		$changed(MIXER_ATTEN_OUT) || $changed(VGA_STEP_OUT) |->
			$past(SER_LE_IN) || $past(SER_LE_IN, 2) || $past(SER_LE_IN, 3);
	endproperty
	a_gain_load: assert property (p_gain_load) else $error("gain moved without load");
endmodule : fsd_props

bind fsd_top fsd_props #(.NEWER_VARIANT(NEWER_VARIANT)) u_props (
	.CLK_SYS_IN(CLK_SYS_IN), .NRST_IN(NRST_IN), .SER_DATA_IN(SER_DATA_IN), .SER_CLK_IN(SER_CLK_IN),
	.SER_LE_IN(SER_LE_IN), .REF_OSC_IN(REF_OSC_IN), .RX_VCO_IN(RX_VCO_IN), .TX_VCO_IN(TX_VCO_IN),
	.IF_IN(IF_IN), .AGC_PAD_REQ_IN(AGC_PAD_REQ_IN), .RX_LO_OUT(RX_LO_OUT), .REF_TICK_OUT(REF_TICK_OUT),
	.REF_RUN_OUT(REF_RUN_OUT), .RX_FB_OUT(RX_FB_OUT), .RX_PD_UP_OUT(RX_PD_UP_OUT), .RX_PD_DN_OUT(RX_PD_DN_OUT),
	.TX_FB_OUT(TX_FB_OUT), .TX_PD_UP_OUT(TX_PD_UP_OUT), .TX_PD_DN_OUT(TX_PD_DN_OUT),
	.DEMOD_SAMPLE_OUT(DEMOD_SAMPLE_OUT), .DEMOD_DAC_OUT(DEMOD_DAC_OUT), .PAD_ATTEN_OUT(PAD_ATTEN_OUT),
	.MIXER_ATTEN_OUT(MIXER_ATTEN_OUT), .VGA_STEP_OUT(VGA_STEP_OUT), .AGC_EN_OUT(AGC_EN_OUT));

// File: tb/fsd_host_model.sv
// Host side of the three-wire programming port.
// Assumes one transfer at a time, started by the bench.
`timescale 1ns/1ps
module fsd_host_model (
	input wire logic clk_in,
	output logic ser_data_out,
	output logic ser_clk_out,
	output logic ser_le_out
);
	initial begin
		ser_data_out = 1'b0;
		ser_clk_out = 1'b0;
		ser_le_out = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// Word MSB first
	task automatic send(input logic [19:0] word, input bit load);
		for (int i = 19; i >= 0; i--) begin
			@(negedge clk_in);
			ser_data_out = word[i];
			ser_clk_out = 1'b1;
			repeat (2) @(negedge clk_in);
			ser_clk_out = 1'b0;
			@(negedge clk_in);
		end
		if (load) begin
			ser_le_out = 1'b1;
			repeat (2) @(negedge clk_in);
			ser_le_out = 1'b0;
		end
		// Idle data moves, so a stale bit never looks driven
		repeat (2) @(negedge clk_in);
		ser_data_out = ~ser_data_out;
	endtask : send
endmodule : fsd_host_model

// File: tb/testbench.sv
// Self-checking bench for the synthesizer divider block.
// Assumes the host model drives the serial port; the bench drives the rest.
`timescale 1ns/1ps
module testbench;
	import fsd_pkg::*;
	logic clk, nrst, ref_osc, rx_vco, tx_vco, if_sig, agc_req;
	logic rx_lo, ref_tick, ref_run, rx_fb, rx_up, rx_dn, tx_fb, tx_up, tx_dn, smp, pad, agc;
	logic [7:0] dac;
	logic [1:0] mix, vga;
	logic ref_run_old;
	wire logic ser_d, ser_c, ser_le;
	wire logic [23:0] all_out = {rx_lo, ref_tick, ref_run, rx_fb, rx_up, rx_dn, tx_fb, tx_up, tx_dn, smp, dac, pad,
		mix, vga, agc};
	int fail_count, n_tests;
	int cnt[5];
	int rt[8] = '{1, 2, 3, 4, 5, 6, 6, 6};

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	fsd_host_model host (.clk_in(clk), .ser_data_out(ser_d), .ser_clk_out(ser_c), .ser_le_out(ser_le));

	fsd_top #(.NEWER_VARIANT(1'b1)) dut (
		.CLK_SYS_IN(clk), .NRST_IN(nrst), .SER_DATA_IN(ser_d), .SER_CLK_IN(ser_c), .SER_LE_IN(ser_le),
		.REF_OSC_IN(ref_osc), .RX_VCO_IN(rx_vco), .TX_VCO_IN(tx_vco), .IF_IN(if_sig), .AGC_PAD_REQ_IN(agc_req),
		.RX_LO_OUT(rx_lo), .REF_TICK_OUT(ref_tick), .REF_RUN_OUT(ref_run), .RX_FB_OUT(rx_fb),
		.RX_PD_UP_OUT(rx_up), .RX_PD_DN_OUT(rx_dn), .TX_FB_OUT(tx_fb), .TX_PD_UP_OUT(tx_up),
		.TX_PD_DN_OUT(tx_dn), .DEMOD_SAMPLE_OUT(smp), .DEMOD_DAC_OUT(dac), .PAD_ATTEN_OUT(pad),
		.MIXER_ATTEN_OUT(mix), .VGA_STEP_OUT(vga), .AGC_EN_OUT(agc));

	// Older variant: keep-reference bit must be ignored
	fsd_top #(.NEWER_VARIANT(1'b0)) dut_old (
		.CLK_SYS_IN(clk), .NRST_IN(nrst), .SER_DATA_IN(ser_d), .SER_CLK_IN(ser_c), .SER_LE_IN(ser_le),
		.REF_OSC_IN(ref_osc), .RX_VCO_IN(rx_vco), .TX_VCO_IN(tx_vco), .IF_IN(if_sig), .AGC_PAD_REQ_IN(agc_req),
		.RX_LO_OUT(), .REF_TICK_OUT(), .REF_RUN_OUT(ref_run_old), .RX_FB_OUT(), .RX_PD_UP_OUT(),
		.RX_PD_DN_OUT(), .TX_FB_OUT(), .TX_PD_UP_OUT(), .TX_PD_DN_OUT(), .DEMOD_SAMPLE_OUT(),
		.DEMOD_DAC_OUT(), .PAD_ATTEN_OUT(), .MIXER_ATTEN_OUT(), .VGA_STEP_OUT(), .AGC_EN_OUT());
	////////////////////////////////////////////////////////////////
	task automatic close_out;
		if (fail_count == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Edge counts may slip by one where a count was mid-way at the start
	task automatic chk_n(input int got, input int exp, input int tol);
		n_tests++;
		if (got < exp - tol || got > exp + tol) begin
			fail_count++;
			$display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
		end
	endtask : chk_n

	task automatic wr(input logic [2:0] a, input logic [16:0] d);
		host.send({a, d}, 1'b1);
	endtask : wr

	// VCO rise every 4 cycles, reference every 8, IF half-cycle 64
	task automatic run(input int n);
		logic lo_q;
		cnt = '{default: 0};
		lo_q = rx_lo;
		for (int c = 0; c < n * 4; c++) begin
			@(negedge clk);
			cnt[0] += int'(ref_tick === 1'b1);
			cnt[1] += int'(rx_lo === 1'b1 && lo_q === 1'b0);
			cnt[2] += int'(rx_fb === 1'b1);
			cnt[3] += int'(tx_fb === 1'b1);
			cnt[4] += int'(smp === 1'b1);
			lo_q = rx_lo;
			rx_vco = (c % 4) < 2;
			tx_vco = (c % 4) < 2;
			ref_osc = (c % 8) < 4;
			if_sig = 1'((c / 64) % 2);
		end
	endtask : run
	////////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		ref_osc = 1'b0;
		rx_vco = 1'b0;
		tx_vco = 1'b0;
		if_sig = 1'b0;
		agc_req = 1'b0;
		fail_count = 0;
		n_tests = 0;
		repeat (20) @(negedge clk);
		chk(all_out, 24'h000000);
		nrst = 1'b1;
		// Words before enable: a running divider takes a new modulus only at a reference tick
		wr(FSD_ADDR_REF, 17'h00803);
		wr(FSD_ADDR_RX, 17'h00010);
		wr(FSD_ADDR_TX, 17'h00010);
		wr(FSD_ADDR_MODE, 17'h00003);
		run(96);
		chk_n(cnt[0], 16, 1);
		chk_n(cnt[1], 48, 1);
		chk_n(cnt[2], 24, 1);
		chk_n(cnt[3], 48, 1);
		chk_n(cnt[4], 24, 1);
		chk(24'(dac >= 8'h03 && dac <= 8'h05), 24'h000001);
		for (int r = 0; r < 8; r++) begin
			wr(FSD_ADDR_REF, 17'(r * 2048 + 3));
			run(120);
			chk_n(cnt[4], 60 / rt[r], 1);
		end
		wr(FSD_ADDR_REF, 17'h00400);
		run(4096);
		chk_n(cnt[0], 2, 1);
		wr(FSD_ADDR_REF, 17'h00001);
		wr(FSD_ADDR_TX, 17'h00017);
		run(96);
		chk_n(cnt[3], 33, 3);
		wr(FSD_ADDR_GAIN, 17'h0001f);
		repeat (3) @(negedge clk);
		chk(24'({pad, mix, vga, agc}), 24'h00003c);
		host.send({FSD_ADDR_GAIN, 17'h00000}, 1'b0);
		wr(3'h5, 17'h00000);
		repeat (3) @(negedge clk);
		chk(24'({pad, mix, vga, agc}), 24'h00003c);
		wr(FSD_ADDR_GAIN, 17'h00020);
		for (int i = 0; i < 2; i++) begin
			agc_req = i[0];
			repeat (3) @(negedge clk);
			chk(24'({pad, agc}), 24'({i[0], 1'b1}));
		end
		wr(FSD_ADDR_MODE, 17'h00004);
		repeat (3) @(negedge clk);
		chk(24'({ref_run, ref_run_old}), 24'h000002);
		wr(FSD_ADDR_MODE, 17'h00000);
		run(24);
		chk_n(cnt[0] + cnt[1], 0, 0);
		wr(FSD_ADDR_MODE, 17'h00003);
		chk(24'({ref_run, ref_run_old}), 24'h000003);
		nrst = 1'b0;
		repeat (2) @(negedge clk);
		chk(all_out, 24'h000000);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		chk(24'(ref_run), 24'h000000);
		close_out();
	end
endmodule : testbench
